// ===== pkg/supply_ctrl_pkg.sv
// constants, types and helpers shared by the supply command controller
package supply_ctrl_pkg;

    // clock and soft-start timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SOFT_START_US = 1000;
    localparam int SOFT_START_CYCLES = SOFT_START_US * (CLK_HZ / 1_000_000);

    // fault inputs, one bit each
    localparam int NFAULT = 5;
    localparam int FLT_OVERVOLT = 0;
    localparam int FLT_OVERCUR = 1;
    localparam int FLT_THERMAL = 2;
    localparam int FLT_PHASE = 3;
    localparam int FLT_PROGLINE = 4;
    // faults that refuse output enable from every source while latched
    localparam logic [NFAULT-1:0] START_BLOCK_MASK = 5'h0c;

    // wishbone register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;

    // control register fields and reset values
    localparam int CTRL_PANEL_EN_BIT = 0;
    localparam int CTRL_REMOTE_EN_BIT = 1;
    localparam int CTRL_TRIP_EN_LSB = 8;
    localparam logic PANEL_EN_RST = 1'b1;
    localparam logic REMOTE_EN_RST = 1'b1;
    localparam logic [NFAULT-1:0] TRIP_EN_RST = 5'h1f;

    // command register bits, write-only pulses
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_CLEAR_BIT = 2;

    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_CONTACTOR_BIT = 3;
    localparam int STAT_SOFT_BIT = 4;
    localparam int STAT_CV_BIT = 5;
    localparam int STAT_CC_BIT = 6;
    localparam int STAT_LATCH_LSB = 8;
    localparam int STAT_LIVE_LSB = 16;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_POWERED = 3'b010,
        ST_ALARM = 3'b100
    } ctrl_state_e;

    typedef logic [NFAULT-1:0] fault_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic clear;
    } cmd_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // a command source counts only while its enable is on
    function automatic cmd_s cmd_gate(input cmd_s c, input logic en);
        cmd_s r;
        r.start = c.start & en;
        r.stop = c.stop & en;
        r.clear = c.clear & en;
        return r;
    endfunction : cmd_gate

endpackage : supply_ctrl_pkg

// ===== src/cmd_edge.sv
// rising-edge detector turning command levels into one-cycle pulses
`timescale 1ns/1ps
module cmd_edge
    import supply_ctrl_pkg::*;
#(
    parameter int W = 6
) (
    input logic ref_clk,
    input logic resetn,
    input logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] prev_q;

    // reset to ones so a key already held at reset does not fire
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            prev_q <= '1;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q; // RULE21

endmodule : cmd_edge

// ===== src/softstart_timer.sv
// pre-charge timer that runs while the supply is powered
`timescale 1ns/1ps
module softstart_timer
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES = SOFT_START_CYCLES
) (
    input logic ref_clk,
    input logic resetn,
    input logic run,
    output logic busy
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

    logic [CW-1:0] count_q;

    // a stop restarts the count, so every start gets the full pre-charge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (!run) begin
            count_q <= '0;
        end else if (count_q != LIMIT) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign busy = run && (count_q != LIMIT);

endmodule : softstart_timer

// ===== src/supply_ctrl.sv
// output enable command state machine with wishbone register access
//
// Functional notes
// RULE1 - start is accepted only in standby; it engages the contactor and powers up
// RULE2 - start in alarm or powered state is ignored, outputs unchanged
// RULE3 - engaging sets the contactor output and reports the powered state
// RULE4 - entering powered runs a flagged soft-start pre-charge phase first
// RULE5 - stop in powered state releases the contactor and returns to standby
// RULE6 - stop in standby or alarm has no effect
// RULE7 - a stop from any enabled source overrides all other requests; the code lets a clear in alarm take effect alongside a stop
// RULE8 - while any stop is held, start does not engage; stays in standby
// RULE9 - clear in alarm unlatches the fault and moves to standby
// RULE10 - a latched fault blocks operation until clear or reset; start cannot leave alarm
// RULE11 - reset discards any latched fault and starts without alarm
// RULE12 - clear unlatches a fault only once its live condition is gone
// RULE13 - panel start, stop and clear count only while panel enable is on
// RULE14 - remote pin and computer commands count only while remote enable is on
// RULE15 - both enables may be on; then both sources are accepted alike
// RULE16 - constant-voltage or constant-current regulation is reported on outputs and status
// RULE17 - the regulation report follows the loop mode input automatically
// RULE18 - a latched enabled trip opens the contactor at once and enters alarm
// RULE19 - while thermal or phase faults are latched, enabling is refused everywhere
// RULE20 - after reset: standby, panel and remote enables both on
// RULE21 - commands are edge-detected one-cycle pulses; stop beats start; clear only in alarm
`timescale 1ns/1ps
module supply_ctrl
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned SOFT_CYCLES = SOFT_START_CYCLES
) (
    input logic ref_clk,
    input logic resetn,
    // front panel keys, high while pressed
    input cmd_s panelKeys,
    // external user i/o command pins, high while active
    input cmd_s extPins,
    // live fault conditions from the detectors
    input fault_t faultLive,
    // regulation loop mode: high for voltage control, low for current control
    input logic loopCvMode,
    // wishbone slave
    input wb_req_s wbReq,
    output logic wbAck,
    output logic [31:0] wbDatOut,
    // power stage and indicators
    output logic contactorEngage,
    output logic softStart,
    output logic standbyInd,
    output logic poweredInd,
    output logic alarmInd,
    output logic cvInd,
    output logic ccInd,
    output fault_t faultInd,
    output logic panelEnInd,
    output logic remoteEnInd
);

    // register state
    logic panelEn_q;
    logic remoteEn_q;
    fault_t tripEn_q;
    cmd_s hostCmd_q;
    logic ack_q;
    logic [31:0] datOut_q;

    // control state
    ctrl_state_e state_q;
    ctrl_state_e state_d;
    fault_t faultLatched_q;
    fault_t faultLatched_d;
    logic contactor_q;
    logic softStart_q;
    logic cv_q;
    logic cc_q;

    // command path
    logic [5:0] edgeRise;
    cmd_s panelRise;
    cmd_s extRise;
    cmd_s panelCmd;
    cmd_s remoteCmd;
    logic anyStart;
    logic anyStop;
    logic anyClear;
    logic stopHeld;
    logic startBlock;
    logic clearOk;
    logic timerBusy;
    logic startOk;
    logic softRun;
    logic poweredNext;
    fault_t faultTrip;

    // bus decode
    logic busReq;
    logic busWrite;
    logic hitCtrl;
    logic hitCmd;
    logic hitStatus;
    logic [31:0] readMux;
    logic ctrlWrite;
    logic hostWrite;

    // powered decode shared by the power stage outputs (next state) and the timer run (current state)
    function automatic logic is_powered(input ctrl_state_e s);
        return (s == ST_POWERED);
    endfunction : is_powered

    // ---- wishbone slave ----
    assign busReq = wbReq.cyc && wbReq.stb && !ack_q;
    assign busWrite = busReq && wbReq.we;
    assign hitCtrl = (wbReq.adr == ADR_CTRL);
    assign hitCmd = (wbReq.adr == ADR_CMD);
    assign hitStatus = (wbReq.adr == ADR_STATUS);
    assign ctrlWrite = busWrite && hitCtrl;
    // a command write without byte 0 is acked but carries nothing
    assign hostWrite = busWrite && hitCmd && wbReq.sel[0];

    // one wait state for every access, mapped or not
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    // enables live in byte 0, trip enables in byte 1
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            panelEn_q <= PANEL_EN_RST; // RULE20
            remoteEn_q <= REMOTE_EN_RST; // RULE20
            tripEn_q <= TRIP_EN_RST;
        end else if (ctrlWrite) begin
            if (wbReq.sel[0]) begin
                panelEn_q <= wbReq.dat[CTRL_PANEL_EN_BIT];
                remoteEn_q <= wbReq.dat[CTRL_REMOTE_EN_BIT];
            end
            if (wbReq.sel[1]) begin
                tripEn_q <= wbReq.dat[CTRL_TRIP_EN_LSB +: NFAULT];
            end
        end
    end

    // computer commands become a single-cycle pulse on the remote path
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hostCmd_q <= '0;
        end else if (hostWrite) begin
            hostCmd_q.start <= wbReq.dat[CMD_START_BIT];
            hostCmd_q.stop <= wbReq.dat[CMD_STOP_BIT];
            hostCmd_q.clear <= wbReq.dat[CMD_CLEAR_BIT];
        end else begin
            hostCmd_q <= '0; // RULE21
        end
    end

    always_comb begin
        readMux = '0;
        if (hitCtrl) begin
            readMux[CTRL_PANEL_EN_BIT] = panelEn_q;
            readMux[CTRL_REMOTE_EN_BIT] = remoteEn_q;
            readMux[CTRL_TRIP_EN_LSB +: NFAULT] = tripEn_q;
        end else if (hitStatus) begin
            readMux[STAT_STATE_LSB +: 3] = state_q;
            readMux[STAT_CONTACTOR_BIT] = contactor_q;
            readMux[STAT_SOFT_BIT] = softStart_q;
            readMux[STAT_CV_BIT] = cv_q; // RULE16
            readMux[STAT_CC_BIT] = cc_q; // RULE16
            readMux[STAT_LATCH_LSB +: NFAULT] = faultLatched_q;
            readMux[STAT_LIVE_LSB +: NFAULT] = faultLive;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            datOut_q <= '0;
        end else if (busReq) begin
            datOut_q <= readMux;
        end
    end

    // ---- command sources ----
    cmd_edge #(
        .W(6)
    ) u_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .level({panelKeys, extPins}),
        .rise(edgeRise)
    );

    // panel keys occupy the upper three detector bits
    assign panelRise = edgeRise[5:3];
    assign extRise = edgeRise[2:0];

    assign panelCmd = cmd_gate(panelRise, panelEn_q); // RULE13
    assign remoteCmd = cmd_gate(extRise | hostCmd_q, remoteEn_q); // RULE14

    // either source is taken when both are enabled
    assign anyStart = panelCmd.start | remoteCmd.start; // RULE15
    assign anyStop = panelCmd.stop | remoteCmd.stop; // RULE15
    assign anyClear = panelCmd.clear | remoteCmd.clear; // RULE15

    // held stop levels also veto a start, not only the stop edge
    assign stopHeld = anyStop
        | (panelEn_q & panelKeys.stop)
        | (remoteEn_q & (extPins.stop | hostCmd_q.stop)); // RULE7 RULE8

    assign startBlock = |(faultLatched_q & START_BLOCK_MASK); // RULE19

    // a start counts only with no stop of any kind and no blocking fault
    assign startOk = anyStart && !stopHeld && !startBlock; // RULE1 RULE7

    assign clearOk = anyClear && (state_q == ST_ALARM); // RULE21

    // ---- fault latch ----
    // disabled trip types never latch, whatever their live level
    assign faultTrip = faultLive & tripEn_q; // RULE18

    // a new trip is ored in after the clear, so set always wins over clear
    always_comb begin
        faultLatched_d = faultLatched_q;
        if (clearOk) begin
            faultLatched_d = faultLatched_q & faultLive; // RULE12
        end
        faultLatched_d = faultLatched_d | faultTrip;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            faultLatched_q <= '0; // RULE11
        end else begin
            faultLatched_q <= faultLatched_d;
        end
    end

    // ---- state machine ----
    always_comb begin
        state_d = state_q;
        if (|faultLatched_d) begin
            state_d = ST_ALARM; // RULE18
        end else begin
            case (state_q)
                ST_STANDBY: begin
                    if (startOk) begin
                        state_d = ST_POWERED; // RULE1
                    end else begin
                        state_d = ST_STANDBY; // RULE6
                    end
                end
                ST_POWERED: begin
                    // only stop is tested here, so a start in the same cycle is ignored
                    if (anyStop) begin
                        state_d = ST_STANDBY; // RULE5 RULE7
                    end else begin
                        state_d = ST_POWERED; // RULE2
                    end
                end
                ST_ALARM: begin
                    // start and stop are both ignored in alarm
                    if (clearOk) begin
                        state_d = ST_STANDBY; // RULE9
                    end else begin
                        state_d = ST_ALARM; // RULE2 RULE6 RULE10
                    end
                end
                default: begin
                    state_d = ST_STANDBY;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= ST_STANDBY; // RULE20
        end else begin
            state_q <= state_d;
        end
    end

    // registered outputs look at the next state so they move with the state
    assign poweredNext = is_powered(state_d);
    assign softRun = is_powered(state_q);

    // contactor follows the next state so a trip opens it on the same edge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            contactor_q <= 1'b0;
        end else begin
            contactor_q <= poweredNext; // RULE3
        end
    end

    // ---- soft start ----
    softstart_timer #(
        .CYCLES(SOFT_CYCLES)
    ) u_soft (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(softRun),
        .busy(timerBusy)
    );

    // the flag rises with the contactor, then follows the pre-charge count
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            softStart_q <= 1'b0;
        end else begin
            softStart_q <= poweredNext
                && (!softRun || timerBusy); // RULE4
        end
    end

    // ---- regulation mode report ----
    // lamps stay dark unless the power stage is engaged
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cv_q <= 1'b0;
            cc_q <= 1'b0;
        end else begin
            cv_q <= loopCvMode && poweredNext; // RULE17
            cc_q <= !loopCvMode && poweredNext; // RULE17
        end
    end

    // ---- outputs ----
    assign wbAck = ack_q;
    assign wbDatOut = datOut_q;
    assign contactorEngage = contactor_q;
    assign softStart = softStart_q;
    assign standbyInd = state_q[0];
    assign poweredInd = state_q[1];
    assign alarmInd = state_q[2];
    assign cvInd = cv_q; // RULE16
    assign ccInd = cc_q; // RULE16
    assign faultInd = faultLatched_q;
    assign panelEnInd = panelEn_q;
    assign remoteEnInd = remoteEn_q;

endmodule : supply_ctrl

// ===== sim/supply_ctrl_sva.sv
// assertion checker for the supply command controller
`timescale 1ns/1ps
module supply_ctrl_sva
    import supply_ctrl_pkg::*;
(
    input logic ref_clk,
    input logic resetn,
    input cmd_s panelKeys,
    input cmd_s extPins,
    input fault_t faultLive,
    input logic loopCvMode,
    input logic wbAck,
    input logic contactorEngage,
    input logic softStart,
    input logic standbyInd,
    input logic poweredInd,
    input logic alarmInd,
    input logic cvInd,
    input logic ccInd,
    input fault_t faultInd,
    input logic panelEnInd,
    input logic remoteEnInd
);
    cmd_s pPrev_q, ePrev_q, pR, eR;
    logic startR, stopR, clrR, stopLvl, quiet;
    // prev levels reset high, so a key held through reset never fires
    always_ff @(posedge ref_clk) begin
        pPrev_q <= resetn ? panelKeys : cmd_s'(3'h7);
        ePrev_q <= resetn ? extPins : cmd_s'(3'h7);
    end
    assign pR = cmd_s'(panelKeys & ~pPrev_q & {3{panelEnInd}});
    assign eR = cmd_s'(extPins & ~ePrev_q & {3{remoteEnInd}});
    assign startR = pR.start | eR.start;
    assign stopR = pR.stop | eR.stop;
    assign clrR = pR.clear | eR.clear;
    assign stopLvl = (panelKeys.stop & panelEnInd) | (extPins.stop & remoteEnInd);
    // register commands arrive with the ack, so quiet excludes them
    assign quiet = (faultLive == '0) && !wbAck;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    start_ok_a: assert property (standbyInd && startR && !stopLvl && quiet |=>
        poweredInd && contactorEngage && softStart) else $error("start did not power up");
    powered_keep_a: assert property (poweredInd && startR && !stopR && !stopLvl && quiet |=>
        poweredInd && contactorEngage && !$rose(softStart)) else $error("start disturbed powered");
    alarm_hold_a: assert property (alarmInd && !clrR && !wbAck |=>
        alarmInd && !contactorEngage) else $error("alarm left without clear");
    stop_off_a: assert property (poweredInd && stopR && faultLive == '0 |=>
        standbyInd && !contactorEngage && !softStart) else $error("stop did not release");
    standby_stop_a: assert property (standbyInd && stopR && faultLive == '0 |=> standbyInd)
        else $error("stop left standby");
    stop_veto_a: assert property (standbyInd && stopLvl |=> !contactorEngage)
        else $error("start engaged under stop");
    fault_off_a: assert property (faultInd != '0 |-> alarmInd && !contactorEngage)
        else $error("latched fault without alarm");
    clear_held_a: assert property (alarmInd && clrR && (faultInd & faultLive) != '0 |=>
        alarmInd) else $error("clear with live fault");
    clear_ok_a: assert property (alarmInd && clrR && faultLive == '0 |=>
        standbyInd && faultInd == '0) else $error("clear did not unlatch");
    reset_init_a: assert property ($rose(resetn) |-> standbyInd && faultInd == '0 &&
        panelEnInd && remoteEnInd && !contactorEngage) else $error("bad state after reset");
    reg_follow_a: assert property (poweredInd |-> cvInd == $past(loopCvMode) &&
        ccInd != $past(loopCvMode)) else $error("regulation lamps wrong");
    lamp_off_a: assert property (!poweredInd |-> !cvInd && !ccInd)
        else $error("lamp lit while unpowered");
    panel_gate_a: assert property (!panelEnInd && standbyInd && panelKeys.start &&
        !pPrev_q.start && !eR.start && quiet |=> standbyInd) else $error("disabled panel obeyed");
    remote_gate_a: assert property (!remoteEnInd && standbyInd && extPins.start &&
        !ePrev_q.start && !pR.start && quiet |=> standbyInd) else $error("disabled pins obeyed");
    cover property (poweredInd && stopR);
    cover property (alarmInd && clrR);
    cover property (poweredInd && $fell(softStart));
endmodule : supply_ctrl_sva

bind supply_ctrl supply_ctrl_sva sva_u (.ref_clk, .resetn, .panelKeys, .extPins, .faultLive,
    .loopCvMode, .wbAck, .contactorEngage, .softStart, .standbyInd, .poweredInd, .alarmInd,
    .cvInd, .ccInd, .faultInd, .panelEnInd, .remoteEnInd);

// ===== sim/cmd_source_model.sv
// behavioural model of the front panel keys and external command pins
`timescale 1ns/1ps
module cmd_source_model
    import supply_ctrl_pkg::*;
(
    input logic ref_clk,
    output cmd_s panelKeys,
    output cmd_s extPins
);
    initial begin
        panelKeys = '0;
        extPins = '0;
    end
    // one clock pressed then released, so every press is a fresh edge
    task automatic press(input cmd_s p, input cmd_s e);
        @(posedge ref_clk);
        panelKeys <= p;
        extPins <= e;
        @(posedge ref_clk);
        panelKeys <= '0;
        extPins <= '0;
        @(negedge ref_clk);
    endtask : press
    task automatic hold(input cmd_s p);
        @(posedge ref_clk);
        panelKeys <= p;
    endtask : hold
endmodule : cmd_source_model

// ===== sim/supply_ctrl_tb.sv
// testbench for the supply command controller
`timescale 1ns/1ps
module supply_ctrl_tb import supply_ctrl_pkg::*;;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    cmd_s panelKeys, extPins;
    fault_t faultLive = '0;
    fault_t faultInd;
    logic loopCvMode = 1'b1;
    wb_req_s wbReq = '0;
    logic wbAck, contactorEngage, softStart, standbyInd, poweredInd, alarmInd, cvInd, ccInd;
    logic panelEnInd, remoteEnInd;
    logic [31:0] wbDatOut, rd;
    logic [4:0] st;
    int fail_count = 0;
    int comparisons = 0;
    localparam cmd_s GO = 3'h4;
    localparam cmd_s HALT = 3'h2;
    localparam cmd_s CLR = 3'h1;
    localparam cmd_s NONE = 3'h0;
    always #5 ref_clk = ~ref_clk;
    assign st = {alarmInd, poweredInd, standbyInd, contactorEngage, softStart};
    cmd_source_model keys_u (.ref_clk, .panelKeys, .extPins);
    // short soft-start count keeps the run brief
    supply_ctrl #(.SOFT_CYCLES(8)) dut_u (.ref_clk, .resetn, .panelKeys, .extPins, .faultLive,
        .loopCvMode, .wbReq, .wbAck, .wbDatOut, .contactorEngage, .softStart, .standbyInd,
        .poweredInd, .alarmInd, .cvInd, .ccInd, .faultInd, .panelEnInd, .remoteEnInd);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cycles(input int k);
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cycles
    // waits on ack without a count; the watchdog cuts a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        @(posedge ref_clk);
        while (wbAck !== 1'b1) @(posedge ref_clk);
        rd = wbDatOut;
        wbReq <= '0;
        @(negedge ref_clk);
    endtask : wb
    task automatic report_and_stop();
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        cycles(1);
        chk(32'({panelEnInd, remoteEnInd, st}), 32'h64);
        wb(1'b0, ADR_CTRL, '0);
        chk(rd, 32'h1f03);
        wb(1'b0, 8'h0c, '0);
        chk(rd, '0);
        keys_u.press(GO, NONE);
        chk(32'({cvInd, st}), 32'h2b);
        cycles(10);
        chk(32'(st), 32'h0a);
        wb(1'b0, ADR_STATUS, '0);
        chk(rd, 32'h2a);
        @(posedge ref_clk);
        loopCvMode <= 1'b0;
        cycles(1);
        chk(32'({cvInd, ccInd}), 32'h1);
        keys_u.press(GO, NONE);
        chk(32'(st), 32'h0a);
        keys_u.press(NONE, HALT);
        chk(32'(st), 32'h04);
        keys_u.press(HALT, NONE);
        chk(32'(st), 32'h04);
        keys_u.hold(HALT);
        wb(1'b1, ADR_CMD, 32'h1);
        chk(32'(st), 32'h04);
        keys_u.hold(NONE);
        keys_u.press(HALT, GO);
        chk(32'(st), 32'h04);
        wb(1'b1, ADR_CTRL, 32'h1f02);
        keys_u.press(GO, NONE);
        chk(32'(st), 32'h04);
        wb(1'b1, ADR_CTRL, 32'h1f01);
        keys_u.press(NONE, GO);
        wb(1'b1, ADR_CMD, 32'h1);
        chk(32'(st), 32'h04);
        wb(1'b1, ADR_CTRL, 32'h1f03);
        wb(1'b1, ADR_CMD, 32'h1);
        chk(32'(st), 32'h0b);
        @(posedge ref_clk);
        faultLive <= 5'h04;
        cycles(1);
        chk(32'({faultInd, st}), 32'h090);
        keys_u.press(GO, GO);
        chk(32'({faultInd, st}), 32'h090);
        keys_u.press(HALT, NONE);
        chk(32'({faultInd, st}), 32'h090);
        keys_u.press(CLR, NONE);
        chk(32'({faultInd, st}), 32'h090);
        @(posedge ref_clk);
        faultLive <= '0;
        keys_u.press(NONE, CLR);
        chk(32'({faultInd, st}), 32'h004);
        wb(1'b1, ADR_CTRL, 32'h1b03);
        @(posedge ref_clk);
        faultLive <= 5'h0c;
        @(posedge ref_clk);
        faultLive <= '0;
        wb(1'b0, ADR_STATUS, '0);
        chk(rd, 32'h0804);
        wb(1'b1, ADR_CMD, 32'h4);
        chk(32'({faultInd, st}), 32'h004);
        @(posedge ref_clk);
        faultLive <= 5'h01;
        @(posedge ref_clk);
        faultLive <= '0;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        cycles(1);
        chk(32'({faultInd, st}), 32'h004);
        report_and_stop();
    end
endmodule : supply_ctrl_tb
